// ---- irq_map.svh ----
`ifndef IRQ_MAP_SVH
`define IRQ_MAP_SVH
// Byte offsets of the registers
// Every register sits on its own aligned word
`define OFS_EN_CLEAR 12'h00c
`define OFS_EN_SET 12'h008
`define OFS_INTFLAG 12'h018
`define OFS_INTMASK 12'h010
`define OFS_INTSTATUS 12'h014
// Field positions of the shared enable byte
`define BIT_OVERFLOW 0
`define BIT_ERR 1
`define BIT_SYNC 3
`define BIT_MC0 4
`define BIT_MC1 5
// Implemented bits and reset values
`define EN_USED 8'h3b
`define EN_RESET 8'h00
`define ST_RESET 8'h00
`endif

// ---- irq_pkg.sv ----
package irq_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [11:0] addr_t;
endpackage

// ---- reg_if.sv ----
`timescale 1ns/1ps
// Set and clear write strobes and data from the bus slave to the enable store, and the enable byte back
interface reg_if;
    logic clr_we;
    logic set_we;
    logic [7:0] wdata;
    logic [7:0] en;
    modport slave(output clr_we, output set_we, output wdata, input en);
    modport store(input clr_we, input set_we, input wdata, output en);
endinterface

// ---- enable_store.sv ----
`timescale 1ns/1ps
`include "irq_map.svh"
module enable_store (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Register side
    reg_if.store r
);
    import irq_pkg::*;
    typedef struct packed {
        byte_t en;
    } st_t;
    st_t s_q;
    st_t s_d;

    // One shared enable byte serves both set and clear views
    always_comb begin
        s_d = s_q;
        if (r.set_we) begin
            s_d.en = s_d.en | (r.wdata & `EN_USED);
        end
        if (r.clr_we) begin
            s_d.en = s_d.en & ~(r.wdata & `EN_USED);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{en: `EN_RESET};
        end else begin
            s_q <= s_d;
        end
    end

    assign r.en = s_q.en;
endmodule

// ---- timer_irq_enable_clear.sv ----
`timescale 1ns/1ps
`include "irq_map.svh"
// What this block does
// - Writing one to bit 5 or 4 disables that channel's interrupt
// - Writing one to bit 3 disables the sync-ready interrupt
// - Writing one to bit 1 disables the error interrupt
// - Writing one to bit 0 disables the overflow interrupt
// - Zeros written to the clear register leave enables unchanged
// - Set and clear registers act on one shared enable byte
// - Reading an enable bit returns one while enabled, else zero
module timer_irq_enable_clear (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire irq_pkg::addr_t paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt events from the timer core
    input wire logic ev_overflow,
    input wire logic ev_err,
    input wire logic ev_sync,
    input wire logic ev_mc0,
    input wire logic ev_mc1,
    // Interrupt request and current enables
    output logic irq,
    output irq_pkg::byte_t irq_enable
);
    import irq_pkg::*;
    typedef struct packed {
        byte_t flag;
        byte_t mask;
        logic err;
        logic irq;
    } st_t;
    st_t s_q;
    st_t s_d;
    reg_if r();
    logic acc;
    logic wr;
    logic hit;
    byte_t ev;

    enable_store u_store (
        .pclk(pclk),
        .presetn(presetn),
        .r(r)
    );

    // Zero-wait slave: each access completes in its first access cycle
    assign acc = psel & penable;
    assign wr = acc & pwrite;
    assign hit = (paddr == `OFS_EN_CLEAR) || (paddr == `OFS_EN_SET) ||
                 (paddr == `OFS_INTFLAG) || (paddr == `OFS_INTMASK) ||
                 (paddr == `OFS_INTSTATUS);
    assign r.clr_we = wr & (paddr == `OFS_EN_CLEAR);
    assign r.set_we = wr & (paddr == `OFS_EN_SET);
    assign r.wdata = pwdata[7:0];

    // Event vector in the same layout as the enable byte
    always_comb begin
        ev = 8'h00;
        ev[`BIT_OVERFLOW] = ev_overflow;
        ev[`BIT_ERR] = ev_err;
        ev[`BIT_SYNC] = ev_sync;
        ev[`BIT_MC0] = ev_mc0;
        ev[`BIT_MC1] = ev_mc1;
    end

    // Next state: flags, mask, error and interrupt level
    always_comb begin
        byte_t fl;
        fl = s_q.flag;
        s_d = s_q;
        // Write-one-to-clear first, so a same-cycle event wins
        if (wr && paddr == `OFS_INTFLAG) begin
            fl = fl & ~pwdata[7:0];
        end
        // Only enabled sources latch; disabling a source does not clear a flag it already latched
        fl = (fl | (ev & r.en)) & `EN_USED;
        s_d.flag = fl;
        if (wr && paddr == `OFS_INTMASK) begin
            s_d.mask = pwdata[7:0] & `EN_USED;
        end
        s_d.err = acc & ~hit;
        s_d.irq = |(fl & s_d.mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{flag: `ST_RESET, mask: `ST_RESET, err: 1'b0, irq: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // Zero wait states: read data is a mux of registered state, valid in the access cycle
    assign pready = 1'b1;
    assign prdata = comb_rdata();
    assign pslverr = acc & ~hit;
    assign irq = s_q.irq;
    assign irq_enable = r.en;

    // Read mux presented directly in the access cycle
    function automatic logic [31:0] comb_rdata();
        logic [31:0] d;
        d = 32'h00000000;
        if (paddr == `OFS_EN_CLEAR || paddr == `OFS_EN_SET) begin
            d = {24'h000000, r.en};
        end else if (paddr == `OFS_INTFLAG) begin
            d = {24'h000000, s_q.flag};
        end else if (paddr == `OFS_INTMASK) begin
            d = {24'h000000, s_q.mask};
        end else if (paddr == `OFS_INTSTATUS) begin
            d = {24'h000000, s_q.flag & s_q.mask};
        end
        return d;
    endfunction
endmodule

// ---- irq_clr_asserts.sv ----
`timescale 1ns/1ps
`include "irq_map.svh"
module irq_clr_asserts (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bus and enables
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire irq_pkg::addr_t paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire irq_pkg::byte_t irq_enable
);
    import irq_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Accesses that the slave takes at this edge
    wire acc = psel && penable;
    wire wc = acc && pwrite && paddr == `OFS_EN_CLEAR;
    wire ws = acc && pwrite && paddr == `OFS_EN_SET;
    property p_mc; wc |=> (irq_enable[5:4] & $past(pwdata[5:4])) == 2'h0; endproperty
    a_mc: assert property (p_mc) else $error("mc kept");
    property p_sy; wc && pwdata[3] |=> !irq_enable[3]; endproperty
    a_sy: assert property (p_sy) else $error("sync kept");
    property p_er; wc && pwdata[1] |=> !irq_enable[1]; endproperty
    a_er: assert property (p_er) else $error("err kept");
    property p_ov; wc && pwdata[0] |=> !irq_enable[0]; endproperty
    a_ov: assert property (p_ov) else $error("overflow kept");
    // Zeros must not disturb the other sources
    property p_zr; wc |=> (irq_enable & ~$past(pwdata[7:0])) ==
        ($past(irq_enable) & ~$past(pwdata[7:0])); endproperty
    a_zr: assert property (p_zr) else $error("zero moved");
    property p_st; ws |=> irq_enable == (($past(irq_enable) | $past(pwdata[7:0])) & 8'h3b);
    endproperty
    a_st: assert property (p_st) else $error("set lost");
    property p_rd; acc && !pwrite && paddr == `OFS_EN_CLEAR |-> prdata == {24'h0, irq_enable};
    endproperty
    a_rd: assert property (p_rd) else $error("bad read");
    property p_rs; (irq_enable & 8'hc4) == 8'h00; endproperty
    a_rs: assert property (p_rs) else $error("rsv set");
endmodule
bind timer_irq_enable_clear irq_clr_asserts chk (.*);

// ---- test_timer_irq_enable_clear.sv ----
`timescale 1ns/1ps
module test_timer_irq_enable_clear;
    import irq_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic ev_overflow, ev_err, ev_sync, ev_mc0, ev_mc1, err_seen;
    addr_t paddr;
    logic [31:0] pwdata, prdata, r;
    byte_t irq_enable;
    byte_t clr[4] = '{8'h30, 8'h08, 8'h02, 8'h01};
    byte_t want[4] = '{8'h0b, 8'h03, 8'h01, 8'h00};
    int num_errors, checks, n;
    timer_irq_enable_clear dut (.*);
    // Bus clock, 40 ns
    initial begin
        pclk = 0;
        forever #20 pclk = ~pclk;
    end
    task chk(input logic [31:0] s, e);
        checks++;
        if (s !== e) begin
            num_errors++;
            $display("FAIL %0t got %h want %h", $time, s, e);
        end
    endtask
    task stop_test;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // One transfer; the idle edge at the end keeps strobes from colliding
    task bus(input logic w, input addr_t a, input byte_t d);
        {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, 24'h0, d};
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do @(posedge pclk); while (pready !== 1'h1 && ++n < 9);
        if (pready !== 1'h1) begin
            num_errors++;
            stop_test();
        end
        r = prdata;
        err_seen = pslverr;
        {psel, penable} <= 2'h0;
        @(posedge pclk);
    endtask
    // Fire every event source for one cycle
    task fire;
        {ev_mc1, ev_mc0, ev_sync, ev_err, ev_overflow} <= 5'h1f;
        @(posedge pclk);
        {ev_mc1, ev_mc0, ev_sync, ev_err, ev_overflow} <= 5'h00;
        repeat (2) @(posedge pclk);
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
        {ev_mc1, ev_mc0, ev_sync, ev_err, ev_overflow} = 5'h00;
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        bus(0, 12'h00c, 8'h00);
        chk(r, 32'h0);
        bus(1, 12'h008, 8'hff);
        bus(0, 12'h00c, 8'h00);
        chk(r, 32'h3b);
        foreach (clr[i]) begin
            bus(1, 12'h00c, clr[i]);
            bus(0, 12'h008, 8'h00);
            chk(r, {24'h0, want[i]});
        end
        chk(irq_enable, 32'h0);
        bus(0, 12'h020, 8'h00);
        chk(err_seen, 32'h1);
        chk(r, 32'h0);
        $display("clear test done");
        bus(1, 12'h008, 8'h01);
        bus(1, 12'h010, 8'h01);
        fire();
        chk(irq, 32'h1);
        bus(0, 12'h014, 8'h00);
        chk(r, 32'h1);
        bus(1, 12'h00c, 8'h01);
        bus(1, 12'h018, 8'h01);
        fire();
        chk(irq, 32'h0);
        bus(0, 12'h014, 8'h00);
        chk(r, 32'h0);
        $display("irq test done");
        stop_test();
    end
endmodule
